// *** rtc_serial_pkg.sv ***
package rtc_serial_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int          BYTE_W    = 8;
    localparam int          BIT_CNT_W = 3;
    localparam int          REG_COUNT = 16;
    localparam int          IDX_W     = 4;
    localparam int          FIFO_DEPTH = 16;
    localparam int          DIR_BIT   = 7;

    // ****************************************************************
    // Constants met by the logic
    // ****************************************************************
    localparam logic [BIT_CNT_W-1:0] BIT_LAST  = 3'h7;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_STEP  = 3'h1;
    localparam logic [IDX_W-1:0]     IDX_STEP  = 4'h1;
    localparam logic [BYTE_W-1:0]    BYTE_ZERO = 8'h00;
    localparam logic                 DIR_WRITE = 1'h1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        LINK_ADDR  = 2'h0,
        LINK_READ  = 2'h1,
        LINK_WRITE = 2'h2
    } link_state_e;

    typedef struct packed {
        logic [BYTE_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } wr_word_s;

    typedef logic [REG_COUNT-1:0][BYTE_W-1:0] reg_image_t;

    localparam wr_word_s WR_WORD_ZERO = '{addr: 8'h00, data: 8'h00};

endpackage : rtc_serial_pkg

// *** sync_2ff.sv ***
`timescale 1ns/1ps

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // ****************************************************************
    // First stage is read by the second stage only
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : sync_2ff

// *** fifo_buffer.sv ***
`timescale 1ns/1ps

module fifo_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] PTR_ONE  = AW'(1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg, wptr_next;
    logic [AW-1:0]    rptr_reg, rptr_next;
    logic [CW-1:0]    count_reg, count_next;
    logic             out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic             push;
    logic             pop;

    // ****************************************************************
    // Storage pointers and registered output stage
    // ****************************************************************
    always_comb begin
        push = in_valid && in_ready;
        pop  = (count_reg != '0) && (!out_valid_reg || out_ready);
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        count_next = count_reg;
        out_valid_next = out_valid_reg;
        out_data_next = out_data_reg;
        if (push) begin
            wptr_next = (wptr_reg == PTR_LAST) ? '0 : wptr_reg + PTR_ONE;
        end
        if (pop) begin
            rptr_next = (rptr_reg == PTR_LAST) ? '0 : rptr_reg + PTR_ONE;
            out_data_next = mem[rptr_reg];
            out_valid_next = 1'b1;
        end else if (out_ready) begin
            out_valid_next = 1'b0;
        end
        if (push && !pop) begin
            count_next = count_reg + CNT_ONE;
        end else if (pop && !push) begin
            count_next = count_reg - CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    assign in_ready = (count_reg != CNT_FULL);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

endmodule : fifo_buffer

// *** rtc_serial_port.sv ***
// Operation
// - One shared data pin, both directions
// - Sample input bits on rising clock
// - Drive read bits after falling clock
// - One clock per bit, eight-bit units
// - Device returns read bytes LSB first
// - First byte of frame is address
// - Address MSB selects read or write
// - Accept bursts of any length
// - Address advances after every data byte
// - Read burst wraps 0Fh to 00h
// - Write burst wraps 8Fh to 80h
// - Time copy refreshed at enable rise
// - Read address plus 80h writes same register
`timescale 1ns/1ps

module rtc_serial_port #(
    parameter int FIFO_DEPTH = rtc_serial_pkg::FIFO_DEPTH
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      sclk,
    input  wire logic                      ce,
    input  wire logic                      io_in,
    output      logic                      io_out,
    output      logic                      io_oe,
    input  wire rtc_serial_pkg::reg_image_t time_image,
    output      logic                      wr_valid,
    output      rtc_serial_pkg::wr_word_s  wr_word,
    input  wire logic                      wr_ready,
    output      logic                      wr_drop
);

    // ****************************************************************
    // Link side state, clocked by sclk, cleared while enable is low except toggle_reg and lword_reg
    // ****************************************************************
    rtc_serial_pkg::link_state_e            state_reg, state_next;
    logic [rtc_serial_pkg::BIT_CNT_W-1:0]   bit_cnt_reg, bit_cnt_next;
    logic [rtc_serial_pkg::BYTE_W-1:0]      shift_reg, shift_next;
    logic [rtc_serial_pkg::BYTE_W-1:0]      addr_reg, addr_next;
    logic [rtc_serial_pkg::BYTE_W-1:0]      byte_in;
    logic [rtc_serial_pkg::BYTE_W-1:0]      addr_inc;
    logic                                   byte_done;
    logic                                   link_rst_n;
    logic                                   io_out_reg, io_out_next;
    logic                                   io_oe_reg, io_oe_next;
    logic                                   toggle_reg, toggle_next;
    rtc_serial_pkg::wr_word_s               lword_reg, lword_next;

    // ****************************************************************
    // Core side state, clocked by mclk
    // ****************************************************************
    logic [1:0]                             sync_out;
    logic                                   ce_seen_reg, ce_seen_next;
    logic                                   tog_seen_reg, tog_seen_next;
    logic                                   pend_valid_reg, pend_valid_next;
    rtc_serial_pkg::wr_word_s               pend_word_reg, pend_word_next;
    logic                                   drop_reg, drop_next;
    rtc_serial_pkg::reg_image_t             snap_reg, snap_next;
    logic                                   fifo_in_ready;
    logic                                   ce_rise;
    logic                                   tog_event;

    // Enable low holds the link side in its start state, except toggle_reg and lword_reg
    assign link_rst_n = rst_n & ce;

    // ****************************************************************
    // Bit and byte framing
    // ****************************************************************
    always_comb begin
        byte_in = {io_in, shift_reg[rtc_serial_pkg::BYTE_W-1:1]};
        byte_done = (bit_cnt_reg == rtc_serial_pkg::BIT_LAST);
        // Low nibble wraps, upper nibble keeps the 00h or 80h bank
        addr_inc = {addr_reg[rtc_serial_pkg::BYTE_W-1:
                             rtc_serial_pkg::IDX_W],
                    addr_reg[rtc_serial_pkg::IDX_W-1:0]
                        + rtc_serial_pkg::IDX_STEP};
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg + rtc_serial_pkg::BIT_STEP;
        shift_next = byte_in;
        addr_next = addr_reg;
        toggle_next = toggle_reg;
        lword_next = lword_reg;
        if (byte_done) begin
            unique case (state_reg)
                rtc_serial_pkg::LINK_ADDR: begin
                    addr_next = byte_in;
                    if (byte_in[rtc_serial_pkg::DIR_BIT]
                            == rtc_serial_pkg::DIR_WRITE) begin
                        state_next = rtc_serial_pkg::LINK_WRITE;
                    end else begin
                        state_next = rtc_serial_pkg::LINK_READ;
                    end
                end
                rtc_serial_pkg::LINK_READ: begin
                    addr_next = addr_inc;
                end
                rtc_serial_pkg::LINK_WRITE: begin
                    lword_next.addr = addr_reg;
                    lword_next.data = byte_in;
                    toggle_next = ~toggle_reg;
                    addr_next = addr_inc;
                end
                default: begin
                    state_next = rtc_serial_pkg::LINK_ADDR;
                end
            endcase
        end
    end

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_reg <= rtc_serial_pkg::LINK_ADDR;
            bit_cnt_reg <= rtc_serial_pkg::BIT_FIRST;
            shift_reg <= rtc_serial_pkg::BYTE_ZERO;
            addr_reg <= rtc_serial_pkg::BYTE_ZERO;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
        end
    end

    // ****************************************************************
    // Write word hand-off, kept across frames so the toggle stays true
    // ****************************************************************
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_reg <= 1'b0;
            lword_reg <= rtc_serial_pkg::WR_WORD_ZERO;
        end else begin
            toggle_reg <= toggle_next;
            lword_reg <= lword_next;
        end
    end

    // ****************************************************************
    // Read data driver on the falling edge
    // ****************************************************************
    always_comb begin
        // Snapshot is frozen for the frame, so this read is stable
        io_out_next = snap_reg[addr_reg[rtc_serial_pkg::IDX_W-1:0]]
                              [bit_cnt_reg];
        io_oe_next = (state_reg == rtc_serial_pkg::LINK_READ);
    end

    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            io_out_reg <= 1'b0;
            io_oe_reg <= 1'b0;
        end else begin
            io_out_reg <= io_out_next;
            io_oe_reg <= io_oe_next;
        end
    end

    assign io_out = io_out_reg;
    assign io_oe = io_oe_reg;

    // ****************************************************************
    // Crossing into mclk
    // ****************************************************************
    sync_2ff #(
        .WIDTH    (2)
    ) u_sync (
        .clk      (mclk),
        .rst_n    (rst_n),
        .async_in ({toggle_reg, ce}),
        .sync_out (sync_out)
    );

    always_comb begin
        ce_rise = sync_out[0] && !ce_seen_reg;
        tog_event = sync_out[1] != tog_seen_reg;
        ce_seen_next = sync_out[0];
        tog_seen_next = sync_out[1];
        snap_next = snap_reg;
        if (ce_rise) begin
            snap_next = time_image;
        end
        pend_valid_next = pend_valid_reg && !fifo_in_ready;
        pend_word_next = pend_word_reg;
        drop_next = 1'b0;
        if (tog_event) begin
            if (pend_valid_next) begin
                drop_next = 1'b1;
            end else begin
                pend_valid_next = 1'b1;
                pend_word_next = lword_reg;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ce_seen_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
            snap_reg <= '0;
            pend_valid_reg <= 1'b0;
            pend_word_reg <= rtc_serial_pkg::WR_WORD_ZERO;
            drop_reg <= 1'b0;
        end else begin
            ce_seen_reg <= ce_seen_next;
            tog_seen_reg <= tog_seen_next;
            snap_reg <= snap_next;
            pend_valid_reg <= pend_valid_next;
            pend_word_reg <= pend_word_next;
            drop_reg <= drop_next;
        end
    end

    assign wr_drop = drop_reg;

    // ****************************************************************
    // Write word queue toward the register side
    // ****************************************************************
    fifo_buffer #(
        .WIDTH     ($bits(rtc_serial_pkg::wr_word_s)),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rst_n     (rst_n),
        .in_valid  (pend_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_word_reg),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

endmodule : rtc_serial_port

// *** rtc_serial_port_chk.sv ***
`timescale 1ns/1ps

module rtc_serial_port_chk #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic                       mclk,
    input wire logic                       rst_n,
    input wire logic                       sclk,
    input wire logic                       ce,
    input wire logic                       io_in,
    input wire logic                       io_out,
    input wire logic                       io_oe,
    input wire rtc_serial_pkg::reg_image_t time_image,
    input wire logic                       wr_valid,
    input wire rtc_serial_pkg::wr_word_s   wr_word,
    input wire logic                       wr_ready,
    input wire logic                       wr_drop
);
    // ********************
    // Frame tracking
    // ********************
    logic [7:0]                 cnt_reg;
    logic [7:0]                 addr_reg;
    rtc_serial_pkg::reg_image_t snap_reg;
    logic [3:0]                 idx;

    always_ff @(posedge sclk or negedge ce) begin
        if (!ce) begin
            cnt_reg  <= 8'h00;
            addr_reg <= 8'h00;
        end else begin
            if (cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg < 8'h08) addr_reg <= {io_in, addr_reg[7:1]};
        end
    end

    always_ff @(posedge sclk) begin
        if (cnt_reg == 8'h00) snap_reg <= time_image;
    end

    assign idx = addr_reg[3:0] + cnt_reg[6:3] - 4'h1;

    sequence s_read_data;
        cnt_reg >= 8'h08 && !addr_reg[7];
    endsequence

    a_oe_ce_low: assert property (@(posedge mclk) disable iff (!rst_n)
        !ce |-> !io_oe) else $error("pin driven outside a frame");
    a_out_after_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        (sclk && $past(sclk)) |-> $stable(io_out) && $stable(io_oe))
        else $error("pin changed while serial clock high");
    a_quiet_addr: assert property (@(posedge sclk) disable iff (!rst_n || !ce)
        cnt_reg < 8'h08 |-> !io_oe) else $error("pin driven in address byte");
    a_quiet_write: assert property (@(posedge sclk) disable iff (!ce)
        (cnt_reg >= 8'h08 && addr_reg[7]) |-> !io_oe)
        else $error("pin driven during write");
    a_drive_read: assert property (@(posedge sclk) disable iff (!ce)
        s_read_data |-> io_oe) else $error("pin not driven during read");
    a_read_bits: assert property (@(posedge sclk) disable iff (!ce)
        s_read_data |-> io_out == snap_reg[idx][cnt_reg[2:0]])
        else $error("wrong read bit");
    a_wr_bank: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_valid |-> wr_word.addr[7]) else $error("write word outside write bank");
    a_wr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_valid && !wr_ready) |=> wr_valid && $stable(wr_word))
        else $error("write word not held");
endmodule : rtc_serial_port_chk

bind rtc_serial_port rtc_serial_port_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .ce(ce), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .time_image(time_image),
    .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready),
    .wr_drop(wr_drop));

// *** rtc_host_model.sv ***
`timescale 1ns/1ps

module rtc_host_model (
    output logic      sclk,
    output logic      ce,
    output logic      host_oe,
    output logic      host_dat,
    input  wire logic io_line
);
    initial begin
        sclk = 1'b0;
        ce = 1'b0;
        host_oe = 1'b0;
        host_dat = 1'b0;
    end

    task automatic open_frame();
        #7.3 ce = 1'b1;
        #20;
    endtask : open_frame

    // Serial clock stands low during gap and between bytes
    task automatic xfer(input logic [7:0] tx, input logic drive,
                        input int nbits, input int gap,
                        output logic [7:0] rx);
        rx = 8'h00;
        #(30 * gap);
        for (int i = 0; i < nbits; i++) begin
            host_oe = drive;
            host_dat = tx[i];
            #15 sclk = 1'b1;
            rx[i] = io_line;
            #15 sclk = 1'b0;
        end
        host_oe = 1'b0;
    endtask : xfer

    task automatic close_frame();
        #10 ce = 1'b0;
        #20;
    endtask : close_frame
endmodule : rtc_host_model

// *** rtc_three_wire_serial_port_tb.sv ***
`timescale 1ns/1ps

module rtc_three_wire_serial_port_tb;
    // ********************
    // Bench
    // ********************
    logic mclk = 1'b0, rst_n, wr_ready, float_reg = 1'b0, io_line;
    logic sclk, ce, host_oe, host_dat, io_out, io_oe, wr_valid, wr_drop;
    rtc_serial_pkg::reg_image_t img, snap_exp;
    rtc_serial_pkg::wr_word_s   wr_word;
    rtc_serial_pkg::wr_word_s   got_q[$];
    int n_mismatch = 0, compares = 0, n_drop = 0;

    always #2 mclk = ~mclk;
    always @(posedge mclk) float_reg <= ~float_reg;
    assign io_line = io_oe ? io_out : (host_oe ? host_dat : float_reg);

    rtc_serial_port #(.FIFO_DEPTH(16)) dut (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .ce(ce), .io_in(io_line),
        .io_out(io_out), .io_oe(io_oe), .time_image(img),
        .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready),
        .wr_drop(wr_drop));
    rtc_host_model host (.sclk(sclk), .ce(ce), .host_oe(host_oe),
        .host_dat(host_dat), .io_line(io_line));

    always @(posedge mclk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_word);
        if (wr_drop === 1'b1) n_drop++;
    end

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_word(input rtc_serial_pkg::wr_word_s got,
                            input rtc_serial_pkg::wr_word_s exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic t_read(input logic [7:0] a, input int n, input logic flip);
        logic [7:0] rx;
        logic [3:0] ix;
        snap_exp = img;
        host.open_frame();
        host.xfer(a, 1'b1, 8, 0, rx);
        if (flip) @(negedge mclk) img = ~img;
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h00, 1'b0, 8, 0, rx);
            ix = a[3:0] + 4'(i);
            cmp_byte(rx, snap_exp[ix]);
        end
        host.close_frame();
        cmp_byte({7'h00, io_oe}, 8'h00);
    endtask : t_read

    task automatic t_write(input logic [7:0] a, input int n, input int gap,
                           input logic ovf);
        logic [7:0] rx;
        logic [3:0] ix;
        int w;
        got_q.delete();
        n_drop = 0;
        w = 0;
        @(negedge mclk) wr_ready = !ovf;
        host.open_frame();
        host.xfer(a, 1'b1, 8, 0, rx);
        for (int i = 0; i < n; i++) host.xfer(8'h30 + 8'(i), 1'b1, 8, gap, rx);
        host.close_frame();
        @(negedge mclk) wr_ready = 1'b1;
        while (got_q.size() + n_drop < n && w < 500) begin
            @(negedge mclk);
            w++;
        end
        cmp_byte(8'(got_q.size() + n_drop), 8'(n));
        cmp_byte({7'h00, n_drop != 0}, {7'h00, ovf});
        foreach (got_q[i]) begin
            ix = a[3:0] + 4'(i);
            cmp_word(got_q[i], {a[7:4], ix, 8'h30 + 8'(i)});
        end
    endtask : t_write

    task automatic t_abort();
        logic [7:0] rx;
        host.open_frame();
        host.xfer(8'h00, 1'b1, 5, 0, rx);
        host.close_frame();
        t_write(8'h83, 1, 0, 1'b0);
    endtask : t_abort

    task automatic final_report();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        wr_ready = 1'b1;
        for (int i = 0; i < 16; i++) img[i] = 8'(i) * 8'h11 ^ 8'h5a;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        cmp_byte({5'h00, io_oe, wr_valid, wr_drop}, 8'h00);
        t_read(8'h05, 1, 1'b0);
        t_read(8'h0e, 4, 1'b1);
        t_read(8'h03, 1, 1'b0);
        t_abort();
        t_write(8'h8e, 4, 0, 1'b0);
        t_write(8'h80, 24, 1, 1'b1);
        final_report();
    end
endmodule : rtc_three_wire_serial_port_tb
